// >>> design/hspi_pkg.sv
// Shared constants for the host serial and pin interface.
package hspi_pkg;
  // ---------------------------------------------------------------
  // Clock and reset release timing
  // ---------------------------------------------------------------
  localparam int unsigned CORE_HZ     = 100_000_000;
  localparam int unsigned REL_US      = 250;
  localparam int unsigned REL_CYC     = REL_US * (CORE_HZ / 1_000_000);
  localparam int unsigned REL_W       = 16;

  // ---------------------------------------------------------------
  // Serial frame layout
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W      = 10;
  localparam logic [4:0]  SHORT_AW    = 5'h06;
  localparam logic [4:0]  LONG_AW     = 5'h0a;
  localparam logic [4:0]  DATA_BITS   = 5'h08;

  // ---------------------------------------------------------------
  // Register addresses (short space uses the low six bits)
  // ---------------------------------------------------------------
  localparam logic [9:0]  S_WAKE      = 10'h022;
  localparam logic [9:0]  S_FLAG      = 10'h031;
  localparam logic [9:0]  S_MASK      = 10'h032;
  localparam logic [9:0]  S_LEVEL     = 10'h033;
  localparam logic [9:0]  S_DIR       = 10'h034;
  localparam logic [9:0]  S_ENABLE    = 10'h03d;
  localparam logic [9:0]  L_SLEEP0    = 10'h211;
  localparam logic [9:0]  L_RFPIN     = 10'h212;
  localparam logic [9:0]  L_INTERVAL  = 10'h222;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned POL_BIT     = 1;
  localparam int unsigned SCLK_BIT    = 0;
  localparam int unsigned WAKE_EN_BIT = 0;
  localparam int unsigned GO_BIT      = 1;
  localparam int unsigned BEACON_BIT  = 2;
  localparam int unsigned FLAG_WAKE   = 6;
  localparam int unsigned FLAG_SLEEP  = 7;
  localparam int unsigned PIN_N       = 6;
  localparam int unsigned RF_PINS     = 3;
  localparam logic [7:0]  MASK_RST    = 8'hff;
  localparam logic [7:0]  ZERO_RST    = 8'h00;
endpackage

// >>> design/reg_bus_if.sv
// Register access path between the serial slave and the register file.
`timescale 1ns/10ps
interface reg_bus_if;
  logic       wrStb;
  logic       rdStb;
  logic       isLong;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  // The serial slave issues accesses; the register file answers.
  modport spi  (output wrStb, rdStb, isLong, addr, wdata, input rdata);
  modport regs (input wrStb, rdStb, isLong, addr, wdata, output rdata);
endinterface

// >>> design/spi_frame_slave.sv
// Mode 0 serial slave that turns frames into register accesses.
`timescale 1ns/10ps
module spi_frame_slave
  import hspi_pkg::*;
(
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Serial pins, asynchronous to core_clk.
  input  wire logic sck,
  input  wire logic csB,
  input  wire logic sdi,
  output logic      sdo,
  // Register access.
  reg_bus_if.spi    bus
);
  typedef struct packed {
    logic [2:0] sckS;
    logic [1:0] csS;
    logic [1:0] sdiS;
    logic [4:0] cnt;
    logic       isLong;
    logic       rw;
    logic       inData;
    logic [9:0] addr;
    logic [7:0] sh;
    logic       sdo;
    logic       wr;
    logic       rd;
  } spi_t;

  spi_t s_q, s_d;
  logic [4:0] aw;

  // ---------------------------------------------------------------
  // Frame decoder
  // ---------------------------------------------------------------
  // Pins pass two flops; the third sck flop only feeds edge detection.
  always_comb begin
    s_d      = s_q;
    s_d.sckS = {s_q.sckS[1:0], sck};
    s_d.csS  = {s_q.csS[0], csB};
    s_d.sdiS = {s_q.sdiS[0], sdi};
    s_d.wr   = 1'b0;
    s_d.rd   = 1'b0;
    aw       = s_q.isLong ? LONG_AW : SHORT_AW;
    // Read data is captured in the strobe cycle itself, before a
    // clear-on-read register has dropped its contents.
    if (s_q.rd) begin
      s_d.sh = bus.rdata;
    end
    if (s_q.csS[1]) begin
      s_d.cnt    = '0;
      s_d.inData = 1'b0;
      s_d.sdo    = 1'b0;
    end else if (s_q.sckS[1] && !s_q.sckS[2]) begin
      // Rising edge: sample input data.
      if (s_q.cnt == 5'h00) begin
        s_d.isLong = s_q.sdiS[1];
      end else if (s_q.cnt <= aw) begin
        s_d.addr = {s_q.addr[8:0], s_q.sdiS[1]};
      end else if (s_q.cnt == aw + 5'h01) begin
        s_d.rw     = s_q.sdiS[1];
        s_d.inData = 1'b1;
        s_d.rd     = !s_q.sdiS[1];
      end else if (s_q.inData) begin
        if (s_q.rw) begin
          s_d.sh = {s_q.sh[6:0], s_q.sdiS[1]};
        end
        if (s_q.cnt == aw + DATA_BITS + 5'h01) begin
          s_d.wr     = s_q.rw;
          s_d.inData = 1'b0;
        end
      end
      if (s_q.cnt != 5'h1f) begin
        s_d.cnt = s_q.cnt + 5'h01;
      end
    end else if (!s_q.sckS[1] && s_q.sckS[2]) begin
      // Falling edge: present the next read bit.
      if (s_q.inData && !s_q.rw) begin
        s_d.sdo = s_q.sh[7];
        s_d.sh  = {s_q.sh[6:0], 1'b0};
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs to the register file and the pin.
  assign bus.wrStb  = s_q.wr;
  assign bus.rdStb  = s_q.rd;
  assign bus.isLong = s_q.isLong;
  assign bus.addr   = s_q.addr;
  assign bus.wdata  = s_q.sh;
  assign sdo        = s_q.sdo;
endmodule

// >>> design/sleep_timer.sv
// Sleep interval counter driven by sleep clock ticks.
`timescale 1ns/10ps
module sleep_timer
  import hspi_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Control.
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic       periodic,
  input  wire logic [7:0] interval,
  // Status.
  output logic            expire,
  output logic            busy
);
  typedef struct packed {
    logic       busy;
    logic [7:0] cnt;
    logic       expire;
  } tmr_t;

  tmr_t t_q, t_d;

  // Count ticks; periodic mode reloads for the next beacon period.
  always_comb begin
    t_d        = t_q;
    t_d.expire = 1'b0;
    if (stop) begin
      t_d.busy = 1'b0;
    end else if (start) begin
      t_d.busy = 1'b1;
      t_d.cnt  = '0;
    end else if (t_q.busy && tick) begin
      if (t_q.cnt + 8'h01 >= interval) begin
        t_d.expire = 1'b1;
        t_d.cnt    = '0;
        t_d.busy   = periodic;
      end else begin
        t_d.cnt = t_q.cnt + 8'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign expire = t_q.expire;
  assign busy   = t_q.busy;
endmodule

// >>> design/host_spi_pin_interface.sv
// Host facing serial port, alert pin, wake pin and general pins.
//
// Contract
// - Reset input low holds every part of the block in reset.
// - Device leaves reset about 250 us after reset input rises.
// - Alert polarity comes from bit 1 of sleep config register 0x211.
// - Polarity resets to 0, active low; host matches its input.
// - Alert pin only shows events both enabled and unmasked.
// - Alert holds asserted until host reads the event flag register.
// - Wake pin ignored after reset until software enables it.
// - Pin direction register 0x34 sets each general pin direction.
// - Writing 0x33 drives output pins; reading returns pin levels.
// - Pins 0 to 2 can be handed to the radio state machine.
// - Serial input sampled on each rising serial clock edge.
// - Serial output updated on each falling serial clock edge.
// - Serial output driven low while deselected.
// - Radio timing derives from the primary system clock.
// - Sleep clock selectable between 32 kHz and 100 kHz sources.
// - Sleep counters time beacon period or sleep interval.
// - Host picks short or long addressing per transaction.
// - Short frame: 0 bit, then six address bits, MSB first.
// - Long frame: 1 bit, then ten address bits, MSB first.
// - Short frame: bit after address is 0 read, 1 write.
// - Long frame: twelfth bit is 0 read, 1 write.
`timescale 1ns/10ps
module host_spi_pin_interface
  import hspi_pkg::*;
#(
  parameter int unsigned RELEASE_CYCLES = REL_CYC
)
(
  // Primary system clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Serial port pins.
  input  wire logic       sck,
  input  wire logic       csB,
  input  wire logic       sdi,
  output logic            sdo,
  // Alert and wake pins.
  output logic            alertPin,
  input  wire logic       wakePin,
  // General pins.
  input  wire logic [5:0] pinIn,
  output logic      [5:0] pinOut,
  output logic      [5:0] pinOeB,
  // Sleep clock sources.
  input  wire logic       xtalSleepClk,
  input  wire logic       oscSleepClk,
  // Radio state machine side.
  input  wire logic [5:0] radioEvent,
  input  wire logic [2:0] radioPinCtl,
  // Status.
  output logic            deviceReady,
  output logic            wakeReq,
  output logic            sleepBusy
);
  typedef struct packed {
    logic [REL_W-1:0] relCnt;
    logic             ready;
    logic [7:0]       flags;
    logic [7:0]       mask;
    logic [7:0]       enable;
    logic [5:0]       level;
    logic [5:0]       dir;
    logic [7:0]       wakeCtl;
    logic [7:0]       sleep0;
    logic [2:0]       rfPin;
    logic [7:0]       interval;
    logic [2:0]       wakeS;
    logic [5:0]       pinS1;
    logic [5:0]       pinS2;
    logic [2:0]       xtalS;
    logic [2:0]       oscS;
    logic             alert;
    logic [5:0]       pOut;
    logic [5:0]       pOeB;
    logic             wakeReq;
    logic             tick;
  } top_t;

  top_t r_q, r_d;
  reg_bus_if bus ();
  logic      spiRst_b;
  logic      tmrExpire;
  logic      tmrBusy;
  logic      tmrStart;
  logic      tmrStop;
  logic      wakeEdge;
  logic      flagRead;
  logic      pending;

  // ---------------------------------------------------------------
  // Address match
  // ---------------------------------------------------------------
  // True when the current access targets the given space and address.
  function automatic logic hit(input logic isLong,
                               input logic [9:0] addr,
                               input logic wantLong,
                               input logic [9:0] want);
    logic [9:0] a;
    a   = isLong ? addr : {4'h0, addr[5:0]};
    hit = (isLong == wantLong) && (a == want);
  endfunction

  // ---------------------------------------------------------------
  // Serial slave and sleep timer
  // ---------------------------------------------------------------
  // The serial slave stays in reset until the release delay ends.
  assign spiRst_b = rst_b && r_q.ready;

  spi_frame_slave u_spi (
    .core_clk (core_clk),
    .rst_b    (spiRst_b),
    .sck      (sck),
    .csB      (csB),
    .sdi      (sdi),
    .sdo      (sdo),
    .bus      (bus.spi)
  );

  sleep_timer u_tmr (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tick     (r_q.tick),
    .start    (tmrStart),
    .stop     (tmrStop),
    .periodic (r_q.wakeCtl[BEACON_BIT]),
    .interval (r_q.interval),
    .expire   (tmrExpire),
    .busy     (sleepBusy)
  );

  assign tmrBusy = sleepBusy;

  // ---------------------------------------------------------------
  // Register read data
  // ---------------------------------------------------------------
  // Unmapped and reserved locations read as zero.
  always_comb begin
    bus.rdata = ZERO_RST;
    if (hit(bus.isLong, bus.addr, 1'b0, S_FLAG)) begin
      bus.rdata = r_q.flags;
    end else if (hit(bus.isLong, bus.addr, 1'b0, S_MASK)) begin
      bus.rdata = r_q.mask;
    end else if (hit(bus.isLong, bus.addr, 1'b0, S_ENABLE)) begin
      bus.rdata = r_q.enable;
    end else if (hit(bus.isLong, bus.addr, 1'b0, S_LEVEL)) begin
      bus.rdata = {2'b00, r_q.pinS2};
    end else if (hit(bus.isLong, bus.addr, 1'b0, S_DIR)) begin
      bus.rdata = {2'b00, r_q.dir};
    end else if (hit(bus.isLong, bus.addr, 1'b0, S_WAKE)) begin
      bus.rdata = r_q.wakeCtl;
    end else if (hit(bus.isLong, bus.addr, 1'b1, L_SLEEP0)) begin
      bus.rdata = r_q.sleep0;
    end else if (hit(bus.isLong, bus.addr, 1'b1, L_RFPIN)) begin
      bus.rdata = {5'h00, r_q.rfPin};
    end else if (hit(bus.isLong, bus.addr, 1'b1, L_INTERVAL)) begin
      bus.rdata = r_q.interval;
    end
  end

  // ---------------------------------------------------------------
  // Event strobes
  // ---------------------------------------------------------------
  // Reading the flag register is what releases the alert pin.
  assign flagRead = bus.rdStb &&
                    hit(bus.isLong, bus.addr, 1'b0, S_FLAG);
  // Wake pin only counts once software has enabled it.
  assign wakeEdge = r_q.wakeS[1] && !r_q.wakeS[2] &&
                    r_q.wakeCtl[WAKE_EN_BIT];
  assign tmrStop  = wakeEdge;
  assign tmrStart = bus.wrStb && bus.wdata[GO_BIT] &&
                    hit(bus.isLong, bus.addr, 1'b0, S_WAKE);
  // An unmasked flag from an enabled source raises the alert.
  assign pending  = |(r_q.flags & r_q.enable & ~r_q.mask);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    r_d       = r_q;
    // Pin inputs pass two flops before use.
    r_d.wakeS = {r_q.wakeS[1:0], wakePin};
    r_d.pinS1 = pinIn;
    r_d.pinS2 = r_q.pinS1;
    r_d.xtalS = {r_q.xtalS[1:0], xtalSleepClk};
    r_d.oscS  = {r_q.oscS[1:0], oscSleepClk};

    // Release delay counts out after reset rises.
    if (!r_q.ready) begin
      if (r_q.relCnt >= REL_W'(RELEASE_CYCLES - 1)) begin
        r_d.ready = 1'b1;
      end else begin
        r_d.relCnt = r_q.relCnt + REL_W'(1);
      end
    end

    // Sleep tick from the selected source's rising edge.
    if (r_q.sleep0[SCLK_BIT]) begin
      r_d.tick = r_q.oscS[1] && !r_q.oscS[2];
    end else begin
      r_d.tick = r_q.xtalS[1] && !r_q.xtalS[2];
    end

    // Register writes from the serial port.
    if (bus.wrStb) begin
      if (hit(bus.isLong, bus.addr, 1'b0, S_MASK)) begin
        r_d.mask = bus.wdata;
      end
      if (hit(bus.isLong, bus.addr, 1'b0, S_ENABLE)) begin
        r_d.enable = bus.wdata;
      end
      if (hit(bus.isLong, bus.addr, 1'b0, S_LEVEL)) begin
        r_d.level = bus.wdata[5:0];
      end
      if (hit(bus.isLong, bus.addr, 1'b0, S_DIR)) begin
        r_d.dir = bus.wdata[5:0];
      end
      if (hit(bus.isLong, bus.addr, 1'b0, S_WAKE)) begin
        r_d.wakeCtl = bus.wdata & ~(8'h01 << GO_BIT);
      end
      if (hit(bus.isLong, bus.addr, 1'b1, L_SLEEP0)) begin
        r_d.sleep0 = bus.wdata;
      end
      if (hit(bus.isLong, bus.addr, 1'b1, L_RFPIN)) begin
        r_d.rfPin = bus.wdata[2:0];
      end
      if (hit(bus.isLong, bus.addr, 1'b1, L_INTERVAL)) begin
        r_d.interval = bus.wdata;
      end
    end

    // Event flags: a new event wins over a read clear.
    r_d.flags = flagRead ? ZERO_RST : r_q.flags;
    r_d.flags[5:0] = r_d.flags[5:0] | radioEvent;
    r_d.flags[FLAG_WAKE]  = r_d.flags[FLAG_WAKE] | wakeEdge;
    r_d.flags[FLAG_SLEEP] = r_d.flags[FLAG_SLEEP] | tmrExpire;

    // Alert pin level from the polarity bit.
    if (pending) begin
      r_d.alert = r_q.sleep0[POL_BIT];
    end else begin
      r_d.alert = !r_q.sleep0[POL_BIT];
    end

    r_d.wakeReq = wakeEdge && tmrBusy;

    // General pins: radio ownership overrides the software value.
    for (int i = 0; i < PIN_N; i++) begin
      r_d.pOut[i] = r_q.level[i];
      r_d.pOeB[i] = !r_q.dir[i];
    end
    for (int i = 0; i < RF_PINS; i++) begin
      if (r_q.rfPin[i]) begin
        r_d.pOut[i] = radioPinCtl[i];
        r_d.pOeB[i] = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset low holds everything, including the release counter.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      r_q          <= '0;
      r_q.mask     <= MASK_RST;
      r_q.alert    <= 1'b1;
      r_q.pOeB     <= '1;
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign alertPin    = r_q.alert;
  assign pinOut      = r_q.pOut;
  assign pinOeB      = r_q.pOeB;
  assign deviceReady = r_q.ready;
  assign wakeReq     = r_q.wakeReq;
endmodule

// >>> sim/host_spi_pin_interface_properties.sv
// Checker on the top level pins of the host serial and pin interface.
`timescale 1ns/10ps
module host_spi_pin_checker
  import hspi_pkg::*;
#(
  parameter int unsigned RELEASE_CYCLES = REL_CYC
)
(
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       rst_b,
  // Serial and event pins.
  input wire logic       sck,
  input wire logic       csB,
  input wire logic       sdo,
  input wire logic       alertPin,
  input wire logic       wakePin,
  // General pins and radio side.
  input wire logic [5:0] pinOut,
  input wire logic [5:0] pinOeB,
  input wire logic [5:0] radioEvent,
  input wire logic [2:0] radioPinCtl,
  // Status.
  input wire logic       deviceReady,
  input wire logic       wakeReq,
  input wire logic       sleepBusy
);
  int unsigned relCnt;
  logic [3:0]  causeAge;

  // Counts edges since reset release and stops past the delay.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      relCnt <= 32'h0;
    end else if (relCnt < RELEASE_CYCLES + 32'h4) begin
      relCnt <= relCnt + 32'h1;
    end
  end

  // Opens a window after anything that may legally move the alert except a periodic timer expiry.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      causeAge <= 4'h0;
    end else if (radioEvent != 6'h00 || !csB || $changed(wakePin) ||
                 $changed(sleepBusy)) begin
      causeAge <= 4'h8;
    end else if (causeAge != 4'h0) begin
      causeAge <= causeAge - 4'h1;
    end
  end

  // All properties share the core clock and its reset.
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  reset_state_a: assert property ($rose(rst_b) |-> !sdo && alertPin &&
    pinOut == 6'h00 && pinOeB == 6'h3f && !deviceReady && !wakeReq)
    else $error("outputs not at reset values");
  release_early_a: assert property (relCnt + 32'h1 < RELEASE_CYCLES |->
    !deviceReady) else $error("ready before release delay");
  release_late_a: assert property (relCnt > RELEASE_CYCLES + 32'h2 |->
    deviceReady) else $error("not ready after release delay");
  ready_quiet_a: assert property (!deviceReady |-> !sdo)
    else $error("serial output active before ready");
  sdo_deselect_a: assert property (csB [*5] |-> !sdo)
    else $error("serial output not low when deselected");
  sdo_fall_a: assert property ($changed(sdo) |-> !sck)
    else $error("serial output moved while clock high");
  alert_cause_a: assert property ($changed(alertPin) |->
    causeAge != 4'h0) else $error("alert moved without a cause");
  dir_hold_a: assert property (csB [*6] |-> $stable(pinOeB))
    else $error("pin enables moved without a write");
  level_hold_a: assert property (csB [*6] ##0
    $stable(radioPinCtl) [*3] |-> $stable(pinOut))
    else $error("pin drive moved without a cause");
  wake_pulse_a: assert property (wakeReq |->
    ($past(sleepBusy) || $past(sleepBusy, 2)) ##1 !wakeReq)
    else $error("wake request without running timer");
endmodule

bind host_spi_pin_interface host_spi_pin_checker #(
  .RELEASE_CYCLES(RELEASE_CYCLES)
) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .sck(sck), .csB(csB), .sdo(sdo),
  .alertPin(alertPin), .wakePin(wakePin), .pinOut(pinOut),
  .pinOeB(pinOeB), .radioEvent(radioEvent), .radioPinCtl(radioPinCtl),
  .deviceReady(deviceReady), .wakeReq(wakeReq), .sleepBusy(sleepBusy)
);

// >>> sim/spi_host_model.sv
// Host side mode 0 serial master that runs whole register frames.
`timescale 1ns/10ps
module spi_host_model (
  // Serial pins.
  output logic      sck,
  output logic      csB,
  output logic      sdi,
  input  wire logic sdo
);
  localparam int HALF = 80;

  // Clock idles low and the device stays deselected between frames.
  initial begin
    sck = 1'b0;
    csB = 1'b1;
    sdi = 1'b1;
  end

  // Sends one frame; the data byte is captured just before each rise.
  task automatic xfer(input logic isLong, input logic [9:0] addr,
                      input logic wr, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [19:0] bits;
    int          n;
    bits = isLong ? {1'b1, addr, wr, wd} :
                    {1'b0, addr[5:0], wr, wd, 4'h0};
    n = isLong ? 20 : 16;
    #37;
    csB = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = bits[19 - i];
      #HALF;
      if (i >= n - 8) begin
        rd = {rd[6:0], sdo};
      end
      sck = 1'b1;
      #HALF;
      sck = 1'b0;
    end
    #HALF;
    csB = 1'b1;
    sdi = ~sdi;
    #100;
  endtask
endmodule

// >>> sim/tb_host_spi_pin_interface.sv
// Self-checking bench for the host serial and pin interface.
`timescale 1ns/10ps
module tb_host_spi_pin_interface
  import hspi_pkg::*;
;
  localparam int RELC = 20;
  logic       core_clk, rst_b, sck, csB, sdi, sdo, alertPin, wakePin;
  logic [5:0] pinIn, pinOut, pinOeB, radioEvent, extPins;
  logic [2:0] radioPinCtl;
  logic       xtalSleepClk, oscSleepClk, runX, runO;
  logic       deviceReady, wakeReq, sleepBusy;
  logic [7:0] rd;
  int         badCount, checksDone, k;

  host_spi_pin_interface #(.RELEASE_CYCLES(RELC)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .sck(sck), .csB(csB), .sdi(sdi),
    .sdo(sdo), .alertPin(alertPin), .wakePin(wakePin), .pinIn(pinIn),
    .pinOut(pinOut), .pinOeB(pinOeB), .xtalSleepClk(xtalSleepClk),
    .oscSleepClk(oscSleepClk), .radioEvent(radioEvent),
    .radioPinCtl(radioPinCtl), .deviceReady(deviceReady),
    .wakeReq(wakeReq), .sleepBusy(sleepBusy));
  spi_host_model u_host (.sck(sck), .csB(csB), .sdi(sdi), .sdo(sdo));

  // Pin level is the device drive where enabled, else the outside level.
  assign pinIn = (~pinOeB & pinOut) | (pinOeB & extPins);

  // Core clock and the two sleep clocks, which stand still when stopped.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial forever begin
    #1000;
    if (runX) xtalSleepClk = ~xtalSleepClk;
  end
  initial forever begin
    #600;
    if (runO) oscSleepClk = ~oscSleepClk;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      badCount++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Ends the run when a bounded wait ran out.
  task automatic waitOk(input int n, input int lim);
    if (n >= lim) begin
      badCount++;
      $display("Error wait expected done seen timeout");
      closeOut();
    end
  endtask

  // Waits whole cycles and lands just after the rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Register write and checked register read over the serial port.
  task automatic wr(input logic lg, input logic [9:0] a,
                    input logic [7:0] d);
    u_host.xfer(lg, a, 1'b1, d, rd);
  endtask
  task automatic rdc(input string w, input logic lg, input logic [9:0] a,
                     input logic [7:0] e);
    u_host.xfer(lg, a, 1'b0, 8'h00, rd);
    chk(w, e, rd);
  endtask

  // One cycle event pulse from the radio side.
  task automatic ev(input logic [5:0] e);
    cyc(1);
    radioEvent = e;
    cyc(1);
    radioEvent = 6'h00;
    cyc(6);
  endtask

  // Reset values and the release delay.
  task automatic tReset();
    cyc(5);
    chk("alert", 8'h01, {7'h0, alertPin});
    chk("pin enables", 8'h3f, {2'h0, pinOeB});
    rst_b = 1'b1;
    for (k = 0; k < 100 && deviceReady !== 1'b1; k++) cyc(1);
    waitOk(k, 100);
    chk("release", 8'h01, {7'h0, k >= RELC - 1 && k <= RELC + 2});
  endtask

  // Reset values, both address spaces and unmapped places.
  task automatic tRegs();
    rdc("dir", 1'b0, S_DIR, ZERO_RST);
    rdc("mask", 1'b0, S_MASK, MASK_RST);
    rdc("sleep cfg", 1'b1, L_SLEEP0, ZERO_RST);
    rdc("short hole", 1'b0, 10'h000, 8'h00);
    wr(1'b1, 10'h300, 8'h5a);
    rdc("long hole", 1'b1, 10'h300, 8'h00);
    wr(1'b1, L_INTERVAL, 8'h03);
    rdc("interval", 1'b1, L_INTERVAL, 8'h03);
  endtask

  // Direction, drive, read back and radio handover of pins.
  task automatic tPins();
    cyc(1);
    extPins = 6'h2c;
    wr(1'b0, S_DIR, 8'h2a);
    wr(1'b0, S_LEVEL, 8'h1f);
    cyc(4);
    chk("pin enables", 8'h15, {2'h0, pinOeB});
    chk("pin drive", 8'h0a, {2'h0, pinOut & 6'h2a});
    rdc("pin levels", 1'b0, S_LEVEL, 8'h0e);
    cyc(1);
    radioPinCtl = 3'b101;
    wr(1'b1, L_RFPIN, 8'h07);
    cyc(3);
    chk("radio pins", 8'h05, {5'h0, pinOut[2:0]});
    radioPinCtl = 3'b010;
    cyc(3);
    chk("radio pins", 8'h02, {5'h0, pinOut[2:0]});
    wr(1'b1, L_RFPIN, 8'h00);
  endtask

  // Sleep expiry on each clock source, wake pin left disabled.
  task automatic tSleep();
    for (int s = 0; s < 2; s++) begin
      cyc(1);
      runX = (s == 0);
      runO = (s == 1);
      wr(1'b1, L_SLEEP0, 8'(s));
      wr(1'b0, S_WAKE, 8'h02);
      chk("sleep busy", 8'h01, {7'h0, sleepBusy});
      cyc(1);
      wakePin = 1'b1;
      cyc(4);
      wakePin = 1'b0;
      for (k = 0; k < 5000 && sleepBusy !== 1'b0; k++) cyc(1);
      waitOk(k, 5000);
      rdc("expiry flag", 1'b0, S_FLAG, 8'h80);
    end
  endtask

  // Enabled wake pin stops a running sleep count.
  task automatic tWake();
    wr(1'b0, S_WAKE, 8'h03);
    cyc(1);
    wakePin = 1'b1;
    for (k = 0; k < 20 && wakeReq !== 1'b1; k++) cyc(1);
    waitOk(k, 20);
    wakePin = 1'b0;
    cyc(4);
    chk("sleep stop", 8'h00, {7'h0, sleepBusy});
    rdc("wake flag", 1'b0, S_FLAG, 8'h40);
  endtask

  // Mask gating of an enabled event, hold until read, and both polarities.
  task automatic tAlert();
    wr(1'b0, S_ENABLE, 8'h03);
    wr(1'b0, S_MASK, 8'hfe);
    ev(6'h02);
    ev(6'h04);
    chk("alert gated", 8'h01, {7'h0, alertPin});
    ev(6'h01);
    chk("alert low", 8'h00, {7'h0, alertPin});
    cyc(50);
    chk("alert held", 8'h00, {7'h0, alertPin});
    rdc("flags", 1'b0, S_FLAG, 8'h07);
    cyc(4);
    chk("alert idle", 8'h01, {7'h0, alertPin});
    wr(1'b1, L_SLEEP0, 8'h02);
    cyc(4);
    chk("alert idle", 8'h00, {7'h0, alertPin});
    ev(6'h01);
    chk("alert high", 8'h01, {7'h0, alertPin});
    rdc("flags", 1'b0, S_FLAG, 8'h01);
    cyc(4);
    chk("alert idle", 8'h00, {7'h0, alertPin});
  endtask

  // Main sequence.
  initial begin
    rst_b = 1'b0;
    wakePin = 1'b0;
    radioEvent = 6'h00;
    radioPinCtl = 3'h0;
    extPins = 6'h00;
    xtalSleepClk = 1'b0;
    oscSleepClk = 1'b0;
    runX = 1'b0;
    runO = 1'b0;
    badCount = 0;
    checksDone = 0;
    tReset();
    tRegs();
    tPins();
    tSleep();
    tWake();
    tAlert();
    closeOut();
  end
endmodule
